// ---- rtl/epw_regs.svh ----
// Timing constants for the parallel EEPROM page-write host controller.
// What the document requires
// [RULE1] The memory finishes its own programming within 5 ms after a write.
// [RULE2] Without polling, wait the full 5 ms before the next write.
// [RULE3] Successive page byte loads start 0.150 us to 100 us apart.
// [RULE4] After polling reports done, wait 10 us before the next write.
// [RULE5] Between byte loads, output enable may pulse low with write strobe high.
// [RULE6] Each byte load is a plain select- or strobe-controlled write.
// [RULE7] Polling reads follow the ordinary read cycle sequence.
// [RULE8] The memory releases its data pins once select or enable rises.
// [RULE9] With select high the memory idles, floats data, ignores writes.
`ifndef EPW_REGS_SVH
`define EPW_REGS_SVH

`define EPW_AW 15
`define EPW_DW 8
`define EPW_TW 17
`define EPW_CLK_NS 50
`define EPW_PROG_MS 5
`define EPW_PROG_CYC ((`EPW_PROG_MS * 1000000) / `EPW_CLK_NS)
`define EPW_LOAD_MIN_NS 150
`define EPW_LOAD_MIN_CYC ((`EPW_LOAD_MIN_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_LOAD_MAX_US 100
`define EPW_LOAD_MAX_CYC ((`EPW_LOAD_MAX_US * 1000) / `EPW_CLK_NS)
`define EPW_GAP_US 10
`define EPW_GAP_CYC ((`EPW_GAP_US * 1000 + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_ACC_NS 90
`define EPW_ACC_CYC ((`EPW_ACC_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_RD_CYC (`EPW_ACC_CYC + 2)
`define EPW_LOAD_MARGIN 4

`endif

// ---- rtl/epw_pkg.sv ----
// Types shared by the EEPROM page-write host controller.
`default_nettype none
`include "epw_regs.svh"
package epw_pkg;
    typedef enum logic [3:0] {
        EPW_IDLE = 4'h0,
        EPW_WR_SET = 4'h1,
        EPW_WR_PULSE = 4'h3,
        EPW_WR_HOLD = 4'h2,
        EPW_PG_WAIT = 4'h6,
        EPW_PROG = 4'h7,
        EPW_POLL_ACT = 4'h5,
        EPW_POLL_END = 4'h4,
        EPW_GAP = 4'hc,
        EPW_RD_ACT = 4'h8,
        EPW_RD_END = 4'h9
    } epw_state_t;

    typedef struct packed {
        epw_state_t st;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe_n;
        logic [`EPW_AW-1:0] addr;
        logic [`EPW_DW-1:0] dq_o;
        logic [`EPW_DW-1:0] dq_s1;
        logic [`EPW_DW-1:0] dq_s2;
        logic [`EPW_DW-1:0] rd_data;
        logic rd_valid;
        logic rdy;
        logic busy;
        logic wd7;
        logic last;
        logic poll;
        logic pg;
        logic hit;
        logic [2:0] cnt;
    } epw_ctl_t;

    typedef struct packed {
        logic [`EPW_TW-1:0] cnt;
        logic expired;
    } epw_tmr_t;
endpackage
`default_nettype wire

// ---- rtl/epw_tmr_if.sv ----
// Load and expiry signals between the controller and its interval timer.
`timescale 1ns/1ns
`default_nettype none
`include "epw_regs.svh"
interface epw_tmr_if;
    logic load;
    logic [`EPW_TW-1:0] value;
    logic expired;

    modport owner (output load, output value, input expired);
    modport timer (input load, input value, output expired);
endinterface
`default_nettype wire

// ---- rtl/epw_timer.sv ----
// Down-counting interval timer that flags expiry after a loaded count.
`timescale 1ns/1ns
`default_nettype none
`include "epw_regs.svh"
module epw_timer
    import epw_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    epw_tmr_if.timer tmr
);
    epw_tmr_t s;
    epw_tmr_t next_s;

    // A load restarts the count; expiry rises the cycle the count hits zero.
    always_comb begin
        next_s = s;
        if (tmr.load) begin
            next_s.cnt = tmr.value;
        end else if (s.cnt != '0) begin
            next_s.cnt = s.cnt - `EPW_TW'(1);
        end
        next_s.expired = (next_s.cnt == '0);
    end

    // State register, frozen while the enable is low.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s <= '{cnt: '0, expired: 1'b1};
        end else if (en_i) begin
            s <= next_s;
        end
    end

    assign tmr.expired = s.expired;
endmodule
`default_nettype wire

// ---- rtl/epw_ctrl.sv ----
// Host controller that reads, page-writes and polls a parallel EEPROM.
`timescale 1ns/1ns
`default_nettype none
`include "epw_regs.svh"
module epw_ctrl
    import epw_pkg::*;
#(
    parameter int PROG_CYC = `EPW_PROG_CYC
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic CLK_EN_I,
    input wire logic CMD_VALID_I,
    input wire logic CMD_WRITE_I,
    input wire logic CMD_LAST_I,
    input wire logic POLL_EN_I,
    input wire logic [`EPW_AW-1:0] CMD_ADDR_I,
    input wire logic [`EPW_DW-1:0] CMD_DATA_I,
    output logic CMD_READY_O,
    output logic RD_VALID_O,
    output logic [`EPW_DW-1:0] RD_DATA_O,
    output logic BUSY_O,
    output logic MEM_CE_N_O,
    output logic MEM_OE_N_O,
    output logic MEM_WE_N_O,
    output logic [`EPW_AW-1:0] MEM_ADDR_O,
    output logic [`EPW_DW-1:0] MEM_DQ_O,
    output logic MEM_DQ_OE_N_O,
    input wire logic [`EPW_DW-1:0] MEM_DQ_I
);
    localparam epw_ctl_t CTL_RST = '{st: EPW_IDLE, ce_n: 1'b1, oe_n: 1'b1,
        we_n: 1'b1, dq_oe_n: 1'b1, rdy: 1'b1, default: '0};
    localparam logic [2:0] RD_LAST = 3'(`EPW_RD_CYC - 1);

    epw_ctl_t s;
    epw_ctl_t next_s;
    epw_tmr_if tmr ();
    logic take;

    epw_timer u_timer (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .en_i(CLK_EN_I),
        .tmr(tmr.timer)
    );

    assign take = CMD_VALID_I && s.rdy;

    // Sequencer for byte loads, reads, polling and program waits.
    always_comb begin
        next_s = s;
        next_s.rd_valid = 1'b0;
        next_s.dq_s1 = MEM_DQ_I;
        next_s.dq_s2 = s.dq_s1;
        tmr.load = 1'b0;
        tmr.value = '0;
        unique case (s.st)
            EPW_IDLE, EPW_PG_WAIT: begin
                if (take && CMD_WRITE_I) begin
                    // Address and data go out with select low, enable high.
                    next_s.addr = CMD_ADDR_I;
                    next_s.dq_o = CMD_DATA_I;
                    next_s.wd7 = CMD_DATA_I[`EPW_DW-1];
                    next_s.last = CMD_LAST_I;
                    next_s.poll = POLL_EN_I;
                    next_s.ce_n = 1'b0; // [RULE6]
                    next_s.dq_oe_n = 1'b0;
                    next_s.st = EPW_WR_SET;
                end else if (take) begin
                    // A read between loads keeps the write strobe high.
                    next_s.addr = CMD_ADDR_I;
                    next_s.ce_n = 1'b0; // [RULE5]
                    next_s.oe_n = 1'b0;
                    next_s.cnt = RD_LAST;
                    next_s.st = EPW_RD_ACT;
                end else if (s.st == EPW_PG_WAIT && tmr.expired) begin
                    // The load window ran out, so the page is programming.
                    next_s.pg = 1'b0; // [RULE3]
                    next_s.busy = 1'b1;
                    tmr.load = 1'b1;
                    tmr.value = `EPW_TW'(PROG_CYC);
                    next_s.st = EPW_PROG;
                end
            end
            EPW_WR_SET: begin
                next_s.we_n = 1'b0; // [RULE6]
                next_s.st = EPW_WR_PULSE;
            end
            EPW_WR_PULSE: begin
                next_s.we_n = 1'b1;
                next_s.st = EPW_WR_HOLD;
            end
            EPW_WR_HOLD: begin
                // Select rises one cycle after the strobe to hold address.
                next_s.ce_n = 1'b1; // [RULE9]
                next_s.dq_oe_n = 1'b1;
                tmr.load = 1'b1;
                if (s.last) begin
                    next_s.pg = 1'b0;
                    next_s.busy = 1'b1;
                    tmr.value = `EPW_TW'(PROG_CYC); // [RULE2]
                    next_s.st = EPW_PROG;
                end else begin
                    // The window is shortened to cover the next setup cycles.
                    next_s.pg = 1'b1;
                    tmr.value = `EPW_TW'(`EPW_LOAD_MAX_CYC - `EPW_LOAD_MARGIN);
                    next_s.st = EPW_PG_WAIT; // [RULE3]
                end
            end
            EPW_PROG: begin
                if (s.poll) begin
                    next_s.ce_n = 1'b0; // [RULE7]
                    next_s.oe_n = 1'b0;
                    next_s.cnt = RD_LAST;
                    next_s.st = EPW_POLL_ACT;
                end else if (tmr.expired) begin
                    // The memory is done once the full program time passed.
                    next_s.busy = 1'b0; // [RULE1] [RULE2]
                    next_s.st = EPW_IDLE;
                end
            end
            EPW_POLL_ACT, EPW_RD_ACT: begin
                if (s.cnt != 3'h0) begin
                    next_s.cnt = s.cnt - 3'h1;
                end else begin
                    // Sample the synchronised bus and release both strobes on the same edge.
                    next_s.ce_n = 1'b1; // [RULE8]
                    next_s.oe_n = 1'b1;
                    if (s.st == EPW_RD_ACT) begin
                        next_s.rd_data = s.dq_s2;
                        next_s.rd_valid = 1'b1;
                        next_s.st = EPW_RD_END;
                    end else begin
                        next_s.hit = (s.dq_s2[`EPW_DW-1] == s.wd7);
                        next_s.st = EPW_POLL_END;
                    end
                end
            end
            EPW_POLL_END: begin
                if (s.hit) begin
                    tmr.load = 1'b1;
                    tmr.value = `EPW_TW'(`EPW_GAP_CYC); // [RULE4]
                    next_s.st = EPW_GAP;
                end else if (tmr.expired) begin
                    next_s.busy = 1'b0; // [RULE1]
                    next_s.st = EPW_IDLE;
                end else begin
                    next_s.ce_n = 1'b0; // [RULE7]
                    next_s.oe_n = 1'b0;
                    next_s.cnt = RD_LAST;
                    next_s.st = EPW_POLL_ACT;
                end
            end
            EPW_GAP: begin
                if (tmr.expired) begin
                    next_s.busy = 1'b0; // [RULE4]
                    next_s.st = EPW_IDLE;
                end
            end
            EPW_RD_END: begin
                // One idle cycle lets the memory float the bus again.
                next_s.st = s.pg ? EPW_PG_WAIT : EPW_IDLE; // [RULE8]
            end
            default: begin
                next_s = CTL_RST;
            end
        endcase
        next_s.rdy = (next_s.st == EPW_IDLE) || (next_s.st == EPW_PG_WAIT);
    end

    // State register, frozen while the enable is low.
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            s <= CTL_RST;
        end else if (CLK_EN_I) begin
            s <= next_s;
        end
    end

    // Every output is a field of the state register.
    assign CMD_READY_O = s.rdy;
    assign RD_VALID_O = s.rd_valid;
    assign RD_DATA_O = s.rd_data;
    assign BUSY_O = s.busy;
    assign MEM_CE_N_O = s.ce_n;
    assign MEM_OE_N_O = s.oe_n;
    assign MEM_WE_N_O = s.we_n;
    assign MEM_ADDR_O = s.addr;
    assign MEM_DQ_O = s.dq_o;
    assign MEM_DQ_OE_N_O = s.dq_oe_n;

    // Helper counters that measure time since the last write strobe fall, the program start and the gap start.
    logic we_d;
    logic fall;
    logic last_poll;
    epw_state_t st_d;
    logic [`EPW_TW-1:0] fall_cnt;
    logic [`EPW_TW-1:0] end_cnt;
    logic [`EPW_TW-1:0] gap_cnt;

    assign fall = CLK_EN_I && we_d && !MEM_WE_N_O;

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            we_d <= 1'b1;
            st_d <= EPW_IDLE;
            last_poll <= 1'b0;
            fall_cnt <= '0;
            end_cnt <= '0;
            gap_cnt <= '0;
        end else if (CLK_EN_I) begin
            we_d <= MEM_WE_N_O;
            st_d <= s.st;
            fall_cnt <= fall ? `EPW_TW'(1) : fall_cnt + `EPW_TW'(&fall_cnt ? 0 : 1);
            if (s.st == EPW_PROG && st_d != EPW_PROG) begin
                end_cnt <= `EPW_TW'(1);
                gap_cnt <= '0;
                last_poll <= s.poll;
            end else begin
                end_cnt <= end_cnt + `EPW_TW'((&end_cnt || end_cnt == '0) ? 0 : 1);
                if (s.st == EPW_GAP && st_d != EPW_GAP) begin
                    gap_cnt <= `EPW_TW'(1);
                end else begin
                    gap_cnt <= gap_cnt + `EPW_TW'((&gap_cnt || gap_cnt == '0) ? 0 : 1);
                end
            end
        end
    end

    full_wait_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // [RULE2]
        fall && !s.pg && !last_poll && end_cnt != '0 |-> end_cnt >= PROG_CYC)
        else $error("Write started before the full program time.");

    byte_space_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // [RULE3]
        fall && s.pg |-> fall_cnt >= `EPW_LOAD_MIN_CYC && fall_cnt <= `EPW_LOAD_MAX_CYC)
        else $error("Page byte load spacing out of window.");

    post_poll_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // [RULE4]
        fall && !s.pg && last_poll && end_cnt != '0
            |-> gap_cnt >= `EPW_GAP_CYC || end_cnt >= PROG_CYC)
        else $error("Write too soon after polling finished.");

    oe_strobe_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // [RULE5]
        !MEM_OE_N_O |-> MEM_WE_N_O && MEM_DQ_OE_N_O)
        else $error("Output enable low while writing or driving data.");

    byte_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // [RULE6]
        fall |-> !MEM_CE_N_O && MEM_OE_N_O && !MEM_DQ_OE_N_O
            ##1 MEM_WE_N_O && !MEM_CE_N_O && !MEM_DQ_OE_N_O)
        else $error("Byte load strobe sequence broken.");

    read_cycle_a: assert property (@(posedge SYS_CLK_I) // [RULE7]
        disable iff (!RST_N_I || !CLK_EN_I)
        $fell(MEM_OE_N_O) |-> (!MEM_OE_N_O && !MEM_CE_N_O)[*4]
            ##1 (MEM_OE_N_O && MEM_CE_N_O))
        else $error("Read or poll cycle of wrong length.");

    page_two_c: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        fall && s.pg);
    poll_hit_c: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        s.st == EPW_GAP);
    read_done_c: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        RD_VALID_O && s.pg);
endmodule
`default_nettype wire

// ---- dv/epw_mem_model.sv ----
// Behavioural parallel EEPROM seen only through its pins.
`timescale 1ns/1ns
`default_nettype none
module epw_mem_model #(
    parameter int WIN_CYC = 24,
    parameter int PRG_CYC = 24,
    parameter int GAP_CYC = 200
) (
    input wire logic clk_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic dq_oe_n_i,
    input wire logic [14:0] addr_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output int viol_o
);
    logic [7:0] mem [0:32767];
    logic [7:0] pend [int];
    logic [7:0] last_q = 8'h00;
    logic we_q = 1'b1;
    logic oe_q = 1'b1;
    logic wd7 = 1'b0;
    logic polled = 1'b0;
    int win = 0;
    int prg = 0;
    int gap = 0;
    int viol = 0;
    wire drive = !ce_n_i && !oe_n_i && we_n_i;
    wire busy = (win > 0) || (prg > 0);

    // The violation count has a single driver, the pin process below.
    assign viol_o = viol;

    // Array starts with a known pattern.
    initial begin
        foreach (mem[k]) mem[k] = 8'(k) ^ 8'h5a;
    end

    // Drive only while selected and enabled; a released bus flips.
    assign dq_o = !drive ? ~last_q :
        busy ? {~wd7, mem[addr_i][6:0]} : mem[addr_i];

    // Pin sampling, page loading and the self-timed write.
    always @(posedge clk_i) begin
        we_q <= we_n_i;
        oe_q <= oe_n_i;
        if (drive)
            last_q <= dq_o;
        if (!dq_oe_n_i && drive)
            viol <= viol + 1;
        if (gap > 0)
            gap <= gap - 1;
        if (!we_q && we_n_i && !ce_n_i) begin
            if (prg > 0 || gap > 0)
                viol <= viol + 1;
            pend[int'(addr_i)] = dq_i;
            wd7 <= dq_i[7];
            win <= WIN_CYC;
        end else if (win == 1) begin
            win <= 0;
            prg <= PRG_CYC;
        end else if (win > 0) begin
            win <= win - 1;
        end
        if (prg == 1) begin
            foreach (pend[k]) mem[k] = pend[k];
            pend.delete();
        end
        if (prg > 0)
            prg <= prg - 1;
        // A finished read that sees the write done opens the gap.
        if (!oe_q && oe_n_i && busy)
            polled <= 1'b1;
        if (!oe_q && oe_n_i && !busy && polled) begin
            polled <= 1'b0;
            gap <= GAP_CYC;
        end
    end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the EEPROM host controller.
`timescale 1ns/1ns
`default_nettype none
`include "epw_regs.svh"
module testbench;
    import epw_pkg::*;
    localparam int PROG = 300;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cen = 1'b1;
    logic vld = 1'b0;
    logic wr = 1'b0;
    logic lst = 1'b0;
    logic pol = 1'b0;
    logic [`EPW_AW-1:0] adr = '0;
    logic [`EPW_DW-1:0] dat = '0;
    logic rdy, rdv, busy, ce_n, oe_n, we_n, dqoe_n;
    logic [`EPW_AW-1:0] maddr;
    logic [`EPW_DW-1:0] rdd, mdo, mdi;
    int viol;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    epw_ctrl #(.PROG_CYC(PROG)) dut_u (.SYS_CLK_I(clk), .RST_N_I(rst_n),
        .CLK_EN_I(cen), .CMD_VALID_I(vld), .CMD_WRITE_I(wr),
        .CMD_LAST_I(lst), .POLL_EN_I(pol), .CMD_ADDR_I(adr),
        .CMD_DATA_I(dat), .CMD_READY_O(rdy), .RD_VALID_O(rdv),
        .RD_DATA_O(rdd), .BUSY_O(busy), .MEM_CE_N_O(ce_n),
        .MEM_OE_N_O(oe_n), .MEM_WE_N_O(we_n), .MEM_ADDR_O(maddr),
        .MEM_DQ_O(mdo), .MEM_DQ_OE_N_O(dqoe_n), .MEM_DQ_I(mdi));
    epw_mem_model mem_u (.clk_i(clk), .ce_n_i(ce_n), .oe_n_i(oe_n),
        .we_n_i(we_n), .dq_oe_n_i(dqoe_n), .addr_i(maddr), .dq_i(mdo),
        .dq_o(mdi), .viol_o(viol));

    // Clock and a hang limit far above the expected run.
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk_in(input int v, input int lo, input int hi);
        check_count++;
        if (v < lo || v > hi) begin
            miscompares++;
            $display("wrong value at %0t: count %0d", $time, v);
        end
    endtask

    // One command, held until the controller takes it.
    task automatic cmd(input logic w, input logic l, input logic p,
                       input logic [14:0] a, input logic [7:0] d);
        int i;
        @(posedge clk);
        vld <= 1'b1;
        wr <= w;
        lst <= l;
        pol <= p;
        adr <= a;
        dat <= d;
        i = 0;
        // Ready is read mid-cycle, where it stands for the coming edge.
        do begin
            @(negedge clk);
            i++;
        end while (rdy !== 1'b1 && i < 4000);
        @(posedge clk);
        vld <= 1'b0;
    endtask

    task automatic rd(input logic [14:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        int k;
        cmd(1'b0, 1'b0, 1'b0, a, 8'h00);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (rdv !== 1'b1 && k < 20);
        chk_in(k, 5, 5);
        chk(16'(rdd & m), 16'(e & m));
    endtask

    // Waits for busy to rise, then counts the cycles until it falls.
    task automatic idle();
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (busy !== 1'b0 && n < 5000);
    endtask

    task automatic t_reset();
        @(negedge clk);
        chk(16'({rdy, busy, ce_n, oe_n, we_n, dqoe_n}), 16'h002f);
    endtask

    task automatic t_read();
        rd(15'h0123, 8'hff, 8'h79);
        rd(15'h7fff, 8'hff, 8'ha5);
        // A read frozen for three cycles by the clock enable.
        cmd(1'b0, 1'b0, 1'b0, 15'h0042, 8'h00);
        cen <= 1'b0;
        repeat (3) @(posedge clk);
        cen <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rdv !== 1'b1 && n < 20);
        chk_in(n, 5, 5);
        chk(16'(rdd), 16'h0018);
    endtask

    task automatic t_poll();
        cmd(1'b1, 1'b0, 1'b1, 15'h0040, 8'ha5);
        rd(15'h0040, 8'h80, 8'h00);
        cmd(1'b1, 1'b1, 1'b1, 15'h0041, 8'h3c);
        idle();
        chk_in(n, 200, 299);
        rd(15'h0040, 8'hff, 8'ha5);
        rd(15'h0041, 8'hff, 8'h3c);
    endtask

    task automatic t_nopoll();
        cmd(1'b1, 1'b1, 1'b0, 15'h0100, 8'h81);
        idle();
        chk_in(n, PROG, PROG + 260);
        cmd(1'b1, 1'b1, 1'b1, 15'h0101, 8'h7e);
        idle();
        rd(15'h0100, 8'hff, 8'h81);
        rd(15'h0101, 8'hff, 8'h7e);
    endtask

    task automatic t_lapse();
        cmd(1'b1, 1'b0, 1'b1, 15'h0200, 8'h55);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (busy !== 1'b1 && n < 2500);
        chk_in(n, 1900, 2004);
        idle();
        rd(15'h0200, 8'hff, 8'h55);
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_read();
        t_poll();
        t_nopoll();
        t_lapse();
        chk(16'(viol), 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
